// >>> bench/lock_detect_and_enable_regs_properties.sv
`timescale 1ns/1ps
module lock_regs_chk (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [5:0] i_reg_addr,
  input wire [23:0] i_reg_wdata,
  input wire i_xfer_active,
  input wire i_addr_match,
  input wire i_always_on,
  input wire o_reg_rvalid,
  input wire [23:0] o_power_enables,
  input wire o_lock_detect,
  input wire o_lock_lost,
  input wire o_relock_req,
  input wire o_lock_serial_out_pin_oe
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire cfg_wr = i_reg_wr && i_reg_addr == 6'h07;
  wire on = o_power_enables[5];
  wire oe = o_lock_serial_out_pin_oe;
  reg tried_q;
  // A config write rearms the single try, so it must win over a new request
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst)
      tried_q <= 1'b0;
    else if (cfg_wr)
      tried_q <= 1'b0;
    else if (o_relock_req)
      tried_q <= 1'b1;
  end
  a_read_answer:
    assert property (i_reg_rd |=> o_reg_rvalid) else $error("read gave no answer");
  a_read_quiet:
    assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("answer without read");
  a_pin_off:
    assert property (!on && $past(!on) |-> !oe) else $error("pin driven while off");
  a_pin_always:
    assert property (!$past(i_sys_rst) && on && $past(on && i_always_on) |-> oe)
    else $error("pin not always driven");
  a_pin_share:
    assert property (on && $past(on && !i_always_on && i_xfer_active && !i_addr_match) |-> !oe)
    else $error("pin driven on foreign transfer");
  a_pin_match:
    assert property (!$past(i_sys_rst) && on
      && $past(on && !i_always_on && !(i_xfer_active && !i_addr_match)) |-> oe)
    else $error("pin not driven");
  a_relock_loss:
    assert property (o_relock_req |-> o_lock_lost) else $error("relock without loss");
  a_relock_once:
    assert property (o_relock_req |-> !tried_q) else $error("second relock try");
  a_det_off:
    assert property (cfg_wr && !i_reg_wdata[3] |-> ##4 !o_lock_detect [*8])
    else $error("lock while detector off");
endmodule // lock_regs_chk
bind lock_detect_and_enable_regs lock_regs_chk u_chk (.i_clk_sys(i_clk_sys),
  .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_xfer_active(i_xfer_active), .i_addr_match(i_addr_match),
  .i_always_on(i_always_on), .o_reg_rvalid(o_reg_rvalid), .o_power_enables(o_power_enables),
  .o_lock_detect(o_lock_detect), .o_lock_lost(o_lock_lost), .o_relock_req(o_relock_req),
  .o_lock_serial_out_pin_oe(o_lock_serial_out_pin_oe));

// >>> bench/lock_detect_and_enable_regs_tb.sv
`timescale 1ns/1ps
module lock_detect_and_enable_regs_tb;
  typedef struct {logic [5:0] a; logic [23:0] w; logic [23:0] e; logic [2:0] p; logic oe;} row_t;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic ref_in = 1'b0;
  logic osc_in = 1'b0;
  logic xfer = 1'b0;
  logic match = 1'b0;
  logic aon = 1'b0;
  logic sdo_sel = 1'b0;
  logic sdo_bit = 1'b0;
  int n_lost = 0;
  logic wr, rd, rvalid, lock, lost, relock, pin_o, pin_oe;
  logic [5:0] addr;
  logic [23:0] wdata, rdata, pwr;
  int n_errors = 0;
  int checks_done = 0;
  int n_relock = 0;
  // Pin inputs p = {always on, transfer, address match}
  row_t rows [6] = '{'{6'h07, 24'h00_0000, 24'h00_0000, 3'b010, 1'b0},
    '{6'h07, 24'h00_3fff, 24'h00_3fff, 3'b011, 1'b1},
    '{6'h08, 24'h00_0e9f, 24'h00_0e9f, 3'b100, 1'b0},
    '{6'h08, 24'hff_ffff, 24'hdf_ffff, 3'b110, 1'b1},
    '{6'h09, 24'h12_3456, 24'h00_0000, 3'b000, 1'b1},
    '{6'h07, 24'h00_014d, 24'h00_014d, 3'b010, 1'b0}};
  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (relock === 1'b1) n_relock <= n_relock + 1;
  always @(posedge i_clk_sys) if (lost === 1'b1) n_lost <= n_lost + 1;
  reg_host host (.i_clk_sys(i_clk_sys), .i_reg_rvalid(rvalid), .i_reg_rdata(rdata),
    .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));
  lock_detect_and_enable_regs DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_ref_edge_in(ref_in), .i_div_osc_in(osc_in), .i_xfer_active(xfer),
    .i_addr_match(match), .i_always_on(aon), .i_sdo_sel(sdo_sel), .i_sdo_bit(sdo_bit),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_power_enables(pwr),
    .o_lock_detect(lock), .o_lock_lost(lost), .o_relock_req(relock),
    .o_lock_serial_out_pin_o(pin_o), .o_lock_serial_out_pin_oe(pin_oe));
  task end_sim;
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rchk(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok) begin
      n_errors++;
      end_sim();
    end else
      chk(d, exp);
  endtask
  // Periods of 24 clocks keep both levels far above the synchroniser's limit
  task pulses(input int n, input int off);
    for (int k = 0; k < n * 24; k++) begin
      @(posedge i_clk_sys);
      ref_in <= (k % 24) < 12;
      osc_in <= (k % 24) >= off && (k % 24) < off + 12;
    end
  endtask
  initial begin
    repeat (5) @(posedge i_clk_sys);
    chk(pwr, 24'hc1_beff);
    i_sys_rst <= 1'b0;
    rchk(6'h07, 24'h00_014d);
    rchk(6'h08, 24'hc1_beff);
    foreach (rows[i]) begin
      {aon, xfer, match} <= rows[i].p;
      host.wr(rows[i].a, rows[i].w);
      rchk(rows[i].a, rows[i].e);
      chk(pin_oe, rows[i].oe);
    end
    host.wr(6'h07, 24'h00_21c8);
    pulses(4, 2);
    chk(lock, 1'b0);
    pulses(1, 12);
    pulses(4, 2);
    chk(lock, 1'b0);
    pulses(1, 2);
    chk(lock, 1'b1);
    chk(pin_o, 1'b1);
    sdo_sel <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk(pin_o, 1'b0);
    sdo_bit <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk(pin_o, 1'b1);
    sdo_sel <= 1'b0;
    sdo_bit <= 1'b0;
    pulses(2, 99);
    chk(lock, 1'b0);
    chk(24'(n_relock), 24'h00_0001);
    pulses(5, 2);
    chk(lock, 1'b1);
    pulses(2, 99);
    chk(24'(n_relock), 24'h00_0001);
    chk(24'(n_lost), 24'h00_0002);
    host.wr(6'h07, 24'h00_2188);
    pulses(6, 5);
    chk(lock, 1'b0);
    host.wr(6'h07, 24'h00_2048);
    pulses(6, 2);
    chk(lock, 1'b0);
    host.wr(6'h07, 24'h00_2c48);
    pulses(6, 2);
    chk(lock, 1'b1);
    host.wr(6'h07, 24'h00_2c40);
    pulses(6, 2);
    chk(lock, 1'b0);
    end_sim();
  end
endmodule // lock_detect_and_enable_regs_tb

// >>> bench/reg_host.sv
`timescale 1ns/1ps
module reg_host #(parameter bit REF_HIGH = 1'b0) (
  input wire i_clk_sys,
  input wire i_reg_rvalid,
  input wire [23:0] i_reg_rdata,
  output logic o_reg_wr = 1'b0,
  output logic o_reg_rd = 1'b0,
  output logic [5:0] o_reg_addr = 6'h00,
  output logic [23:0] o_reg_wdata = 24'h00_0000
);
  // Power enables always go out with the mandatory bits set
  task wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge i_clk_sys);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= (a == 6'h08) ? {d[23:22], REF_HIGH, d[20:0]} | 24'h00_0e9f : d;
    @(posedge i_clk_sys);
    o_reg_wr <= 1'b0;
  endtask
  task rd(input logic [5:0] a, output logic [23:0] d, output bit ok);
    ok = 1'b0;
    d = 24'h00_0000;
    @(posedge i_clk_sys);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_clk_sys);
    o_reg_rd <= 1'b0;
    repeat (3) begin
      @(posedge i_clk_sys);
      if (!ok && i_reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = i_reg_rdata;
      end
    end
  endtask
endmodule // reg_host

// >>> core/lock_detect_and_enable_regs.v
// How it works
// - Count code 0..7 selects 5,32,96,256,512,2048,8192,65535 consecutive edges.
// - Lock declared after that many in-window edges; a miss restarts the run.
// - Detector enable bit, reset one; cleared means detector idles, no lock.
// - Window type one uses digital timer, zero a 10 ns one-shot.
// - Digital window lasts half, 1, 2, 4, 8, 16, 32, 64 timer cycles.
// - Two-bit field slows the window timer clock, code 00 fastest.
// - Timer runs one-shot per window; test bit keeps its clock running.
// - Auto-relock bit gives one relock attempt after lock fails, until a config write rearms it.
// - Pin enable zero turns pin off; with companion bit one, always driven.
// - Pin enable one, companion zero: driver off during foreign-address transfers.
`timescale 1ns/1ps
`include "lock_detect_defines.vh"

module lock_detect_and_enable_regs (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [5:0] i_reg_addr,
  input wire [23:0] i_reg_wdata,
  input wire i_ref_edge_in,
  input wire i_div_osc_in,
  input wire i_xfer_active,
  input wire i_addr_match,
  input wire i_always_on,
  input wire i_sdo_sel,
  input wire i_sdo_bit,
  output reg [23:0] o_reg_rdata,
  output reg o_reg_rvalid,
  output reg [23:0] o_power_enables,
  output reg o_lock_detect,
  output reg o_lock_lost,
  output reg o_relock_req,
  output reg o_lock_serial_out_pin_o,
  output reg o_lock_serial_out_pin_oe
);

  reg [23:0] cfg_q;
  reg [23:0] pwr_q;
  reg ref_lvl_d1_q;
  reg osc_lvl_d1_q;
  reg win_d1_q;
  reg hit_q;
  reg [15:0] run_q;
  reg lock_q;
  reg tried_q;
  wire ref_lvl;
  wire osc_lvl;
  wire ref_rise;
  wire osc_rise;
  wire win;
  wire win_close;
  wire det_en;
  wire good;
  wire bad;
  wire fail;
  wire [15:0] thr;
  wire cfg_wr;
  wire pin_oe_d;
  wire pin_o_d;

  function [15:0] count_limit;
    input [2:0] code;
    begin
      case (code)
        3'h0: count_limit = 16'h0005;
        3'h1: count_limit = 16'h0020;
        3'h2: count_limit = 16'h0060;
        3'h3: count_limit = 16'h0100;
        3'h4: count_limit = 16'h0200;
        3'h5: count_limit = 16'h0800;
        3'h6: count_limit = 16'h2000;
        default: count_limit = 16'hffff;
      endcase
    end
  endfunction

  assign cfg_wr = i_reg_wr && (i_reg_addr == `LOCK_CFG_ADDR);

  // Register file; reserved bits are stored like the rest
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_q <= `LD_CFG_RST;
      pwr_q <= `PWR_EN_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `LOCK_CFG_ADDR) begin
        cfg_q <= i_reg_wdata;
      end
      if (i_reg_addr == `PWR_EN_ADDR) begin
        pwr_q <= i_reg_wdata;
      end
    end
  end

  // Readback one cycle after the read strobe; unmapped reads return zero
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 24'h00_0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `LOCK_CFG_ADDR: o_reg_rdata <= cfg_q;
          `PWR_EN_ADDR: o_reg_rdata <= pwr_q;
          default: o_reg_rdata <= 24'h00_0000;
        endcase
      end
    end
  end

  // Power enables go out as stored; keeping them at one is up to software
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_power_enables <= `PWR_EN_RST;
    end else begin
      o_power_enables <= pwr_q;
    end
  end

  pin_sync u_ref_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_ref_edge_in),
    .o_level(ref_lvl)
  );

  pin_sync u_osc_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_div_osc_in),
    .o_level(osc_lvl)
  );

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ref_lvl_d1_q <= 1'b0;
      osc_lvl_d1_q <= 1'b0;
      win_d1_q <= 1'b0;
    end else begin
      ref_lvl_d1_q <= ref_lvl;
      osc_lvl_d1_q <= osc_lvl;
      win_d1_q <= win;
    end
  end

  // Edges of signals much faster than the clock are lost; inputs must be divided down
  assign ref_rise = ref_lvl && !ref_lvl_d1_q;
  assign osc_rise = osc_lvl && !osc_lvl_d1_q;
  assign det_en = cfg_q[`DET_EN_BIT];

  lock_window_timer u_win (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_start(ref_rise && det_en),
    .i_digital(cfg_q[`WIN_TYPE_BIT]),
    .i_dur(cfg_q[`WIN_DUR_HI:`WIN_DUR_LO]),
    .i_freq(cfg_q[`TMR_FREQ_HI:`TMR_FREQ_LO]),
    .i_test(cfg_q[`TMR_TEST_BIT]),
    .o_window(win)
  );

  assign win_close = win_d1_q && !win;
  assign thr = count_limit(cfg_q[`CNT_SEL_HI:`CNT_SEL_LO]);
  // First divided edge inside an open window is good
  assign good = det_en && osc_rise && win && !hit_q;
  // Edge outside the window, a second edge, or a window with none
  assign bad = det_en && ((osc_rise && !good) || (win_close && !hit_q && !osc_rise));
  assign fail = bad && lock_q;

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hit_q <= 1'b0;
      run_q <= 16'h0000;
      lock_q <= 1'b0;
    end else if (!det_en) begin
      hit_q <= 1'b0;
      run_q <= 16'h0000;
      lock_q <= 1'b0;
    end else begin
      if (good) begin
        hit_q <= 1'b1;
      end else if (win_close || ref_rise) begin
        hit_q <= 1'b0;
      end
      if (bad) begin
        run_q <= 16'h0000;
        lock_q <= 1'b0;
      end else if (good) begin
        if (run_q < thr) begin
          run_q <= run_q + 16'h0001;
        end
        if (run_q >= thr - 16'h0001) begin
          lock_q <= 1'b1;
        end
      end
    end
  end

  // Single relock try; rearmed only by a config write, a new failure wins over it
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tried_q <= 1'b0;
      o_relock_req <= 1'b0;
      o_lock_lost <= 1'b0;
      o_lock_detect <= 1'b0;
    end else begin
      o_lock_detect <= lock_q;
      o_lock_lost <= fail;
      o_relock_req <= fail && cfg_q[`AUTO_RELOCK_BIT] && !tried_q;
      if (fail && cfg_q[`AUTO_RELOCK_BIT]) begin
        tried_q <= 1'b1;
      end else if (cfg_wr) begin
        tried_q <= 1'b0;
      end
    end
  end

  // Pin drive: off, always on, or released for other chips' transfers
  assign pin_oe_d = !pwr_q[`PIN_EN_BIT] ? 1'b0 :
                    i_always_on ? 1'b1 :
                    !(i_xfer_active && !i_addr_match);
  assign pin_o_d = i_sdo_sel ? i_sdo_bit : lock_q;

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_lock_serial_out_pin_o <= 1'b0;
      o_lock_serial_out_pin_oe <= 1'b0;
    end else begin
      o_lock_serial_out_pin_o <= pin_o_d;
      o_lock_serial_out_pin_oe <= pin_oe_d;
    end
  end

endmodule // lock_detect_and_enable_regs

// >>> core/lock_detect_defines.vh
`ifndef LOCK_DETECT_DEFINES_VH
`define LOCK_DETECT_DEFINES_VH

// Register addresses on the serial register port
`define REG_ADDR_W 6
`define LOCK_CFG_ADDR 6'h07
`define PWR_EN_ADDR 6'h08
`define REG_W 24

// Reset values
`define LD_CFG_RST 24'h00_014d
`define PWR_EN_RST 24'hc1_beff

// Lock detector configuration fields
`define CNT_SEL_HI 2
`define CNT_SEL_LO 0
`define DET_EN_BIT 3
`define WIN_TYPE_BIT 6
`define WIN_DUR_HI 9
`define WIN_DUR_LO 7
`define TMR_FREQ_HI 11
`define TMR_FREQ_LO 10
`define TMR_TEST_BIT 12
`define AUTO_RELOCK_BIT 13

// Block power enable fields
`define PIN_EN_BIT 5
`define DIV_CLK_LOGIC_BIT 7

// Analog one-shot window
`define ONE_SHOT_NS 10
`define CLK_PERIOD_NS 4
`define ONE_SHOT_CYC ((`ONE_SHOT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> core/lock_window_timer.v
`timescale 1ns/1ps
`include "lock_detect_defines.vh"

module lock_window_timer (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_start,
  input wire i_digital,
  input wire [2:0] i_dur,
  input wire [1:0] i_freq,
  input wire i_test,
  output reg o_window
);

  localparam integer ANALOG_LEN_I = `ONE_SHOT_CYC;
  localparam [7:0] ANALOG_LEN = ANALOG_LEN_I[7:0];

  reg [7:0] pre_q;
  reg [7:0] rem_q;
  wire [7:0] pre_lim;
  wire run;
  wire half_tick;
  wire step;

  // Timer clock period grows with the frequency code
  assign pre_lim = (8'h01 << i_freq) - 8'h01;
  // Test mode keeps the timer clock running between windows
  assign run = i_test | o_window;
  assign half_tick = run && (pre_q == pre_lim);
  assign step = i_digital ? half_tick : 1'b1;

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_q <= 8'h00;
      rem_q <= 8'h00;
      o_window <= 1'b0;
    end else begin
      if (i_start && !i_test) begin
        pre_q <= 8'h00;
      end else if (!run || half_tick) begin
        pre_q <= 8'h00;
      end else begin
        pre_q <= pre_q + 8'h01;
      end
      if (i_start) begin
        o_window <= 1'b1;
        // Length counted in half timer cycles: code 0 is one half cycle
        rem_q <= i_digital ? (8'h01 << i_dur) : ANALOG_LEN;
      end else if (o_window && step) begin
        if (rem_q <= 8'h01) begin
          o_window <= 1'b0;
          rem_q <= 8'h00;
        end else begin
          rem_q <= rem_q - 8'h01;
        end
      end
    end
  end

endmodule // lock_window_timer

// >>> core/pin_sync.v
`timescale 1ns/1ps
`include "lock_detect_defines.vh"

module pin_sync (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_async,
  output reg o_level
);

  reg meta_q;
  reg s2_q;
  reg s3_q;

  // A change counts only once the second and third stages agree
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta_q <= i_async;
      s2_q <= meta_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end

endmodule // pin_sync
